// file: verilog/ccf_channel.sv
// Command flag interpretation and status record building for one channel
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Command chain flag fetches next doubleword, run with its own command byte.
// - Each command-chained read or write starts a new record.
// - Length mismatch ends the list unless suppress flag set.
// - Suppressing length error keeps reported residual count unchanged.
// - Suppress flag never prevents breaking a data chain on mismatch.
// - Skip flag runs operation fully but writes no data to memory.
// - Progress flag queues a status record when its command completes.
// - Progress record: zero count, progress flag only, address plus eight.
// - Progress fires on count zero under data chain or device end.
// - Byte count is low half of word two, at most 65535.
// - Zero count on read, write or sense ends list with program check, except in a data-chained doubleword.
// - Status record queued whenever a list completes or is terminated.
// - Status pointer shows where the status record was written.
// - Status word one: subaddress high byte, next-command address below.
// - Status word two: flags high half, residual count low half.
// - Reported address is last executed plus eight, else first command.
// - Flag bits: progress 1, length 2, program check 3, data check 4.
// - Data chain continues same command; address, count and flags change.
// - Flags from word two high byte, data address from word one.
module ccf_channel #(
  parameter int QDEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_rd_req,
  output logic [23:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rd_data,
  output logic dev_start,
  output logic [7:0] dev_cmd,
  output logic dev_new_record,
  input wire logic dev_byte,
  input wire logic dev_end,
  input wire logic dev_data_check,
  output logic [23:0] data_addr,
  output logic data_wr_en,
  output logic [15:0] residual
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic ph_valid, ph_write;
  logic [7:0] ph_addr;
  logic next_ph_valid, next_ph_write;
  logic [7:0] next_ph_addr;
  logic go_pend, next_go_pend;
  logic [23:0] list_addr, next_list_addr, sbuf, next_sbuf, sptr, next_sptr;
  logic [7:0] subaddr, next_subaddr;
  logic [63:0] q_head, rec;
  logic q_ne, q_full, q_push, q_pop;

  always_comb begin
    next_ph_valid = hsel && hready && htrans == ccf_pkg::CCF_HTRANS_NONSEQ;
    next_ph_write = hwrite;
    next_ph_addr = haddr[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= '0;
    end else begin
      ph_valid <= next_ph_valid;
      ph_write <= next_ph_write;
      ph_addr <= next_ph_addr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr = ph_valid && ph_write;
  // Reading the second status word removes the head record
  assign q_pop = ph_valid && !ph_write && ph_addr == ccf_pkg::CCF_REG_SW2;

  // ****************************************
  // Command list engine
  // ****************************************
  ccf_pkg::ccf_state_t state, next_state;
  logic word2, next_word2;
  logic [31:0] w1, next_w1;
  logic [7:0] cmd, next_cmd, flg, next_flg;
  logic [23:0] cur, next_cur, last_done, next_last_done, daddr, next_daddr;
  logic [15:0] cnt, next_cnt;
  logic executed, next_executed, in_dc, next_in_dc;
  logic [15:0] st, next_st;
  logic [15:0] rcnt, next_rcnt;
  logic progress_interrupt_flag_q, next_progress_interrupt_flag_q, len_err;
  logic req, next_req;
  logic was_exec, next_was_exec, long_blk, next_long_blk;
  logic [3:0] op;

  assign op = cmd[3:0];
  wire is_xfer = op == ccf_pkg::CCF_OP_WRITE || op == ccf_pkg::CCF_OP_READ
    || op == ccf_pkg::CCF_OP_SENSE;
  wire is_rd = op == ccf_pkg::CCF_OP_READ || op == ccf_pkg::CCF_OP_SENSE;

  always_comb begin
    next_state = state;
    next_word2 = word2;
    next_w1 = w1;
    next_cmd = cmd;
    next_flg = flg;
    next_cur = cur;
    next_last_done = last_done;
    next_daddr = daddr;
    next_cnt = cnt;
    next_executed = executed;
    next_in_dc = in_dc;
    next_st = st;
    next_rcnt = rcnt;
    next_progress_interrupt_flag_q = 1'b0;
    next_req = 1'b0;
    next_was_exec = state == ccf_pkg::CCF_EXEC;
    next_long_blk = long_blk;
    next_go_pend = go_pend;
    next_list_addr = list_addr;
    next_subaddr = subaddr;
    next_sbuf = sbuf;
    next_sptr = sptr;
    len_err = 1'b0;
    if (wr && ph_addr == ccf_pkg::CCF_REG_LIST) begin
      next_list_addr = hwdata[23:0] & ccf_pkg::CCF_WORD_MASK;
    end
    if (wr && ph_addr == ccf_pkg::CCF_REG_SBUF) begin
      next_sbuf = hwdata[23:0] & ccf_pkg::CCF_WORD_MASK;
    end
    if (wr && ph_addr == ccf_pkg::CCF_REG_CTRL) begin
      next_subaddr = hwdata[7:0];
      next_go_pend = hwdata[8];
    end
    if (q_pop && q_ne) begin
      next_sptr = sbuf;
    end
    case (state)
      ccf_pkg::CCF_IDLE: begin
        if (go_pend) begin
          next_go_pend = 1'b0;
          next_cur = list_addr;
          next_last_done = list_addr;
          next_executed = 1'b0;
          next_long_blk = 1'b0;
          next_in_dc = 1'b0;
          next_word2 = 1'b0;
          next_req = 1'b1;
          next_state = ccf_pkg::CCF_FETCH;
        end
      end
      ccf_pkg::CCF_FETCH: begin
        if (mem_rd_valid) begin
          if (!word2) begin
            next_w1 = mem_rd_data;
            next_word2 = 1'b1;
            next_req = 1'b1;
          end else begin
            next_word2 = 1'b0;
            next_long_blk = 1'b0;
            // Data-chained doublewords keep the first command byte
            if (!in_dc) begin
              next_cmd = w1[ccf_pkg::CCF_CMD_HI:ccf_pkg::CCF_CMD_LO];
            end
            next_daddr = w1[ccf_pkg::CCF_ADDR_HI:ccf_pkg::CCF_ADDR_LO];
            next_flg = mem_rd_data[ccf_pkg::CCF_FLAG_HI:ccf_pkg::CCF_FLAG_LO];
            next_cnt = mem_rd_data[ccf_pkg::CCF_CNT_HI:ccf_pkg::CCF_CNT_LO];
            next_state = ccf_pkg::CCF_EXEC;
          end
        end else begin
          next_req = !mem_rd_req;
        end
      end
      ccf_pkg::CCF_EXEC: begin
        if (is_xfer && cnt == ccf_pkg::CCF_CNT_ZERO && !in_dc && !was_exec) begin
          next_st = ccf_pkg::CCF_ST_PCHK;
          next_rcnt = cnt;
          next_state = ccf_pkg::CCF_QUEUE;
        end else if (dev_data_check) begin
          next_st = ccf_pkg::CCF_ST_DCHK;
          next_rcnt = cnt;
          next_last_done = cur + ccf_pkg::CCF_DW_BYTES;
          next_state = ccf_pkg::CCF_QUEUE;
        end else if (dev_byte && cnt != ccf_pkg::CCF_CNT_ZERO) begin
          next_cnt = cnt - ccf_pkg::CCF_CNT_ONE;
          next_daddr = daddr + 24'h00_0001;
          if (flg[ccf_pkg::CCF_FLAG_DC - 24] && cnt == ccf_pkg::CCF_CNT_ONE) begin
            // Count exhausted: continue with next doubleword of same command
            next_progress_interrupt_flag_q = flg[ccf_pkg::CCF_FLAG_PROGRESS_INTERRUPT_FLAG - 24];
            next_last_done = cur + ccf_pkg::CCF_DW_BYTES;
            next_cur = cur + ccf_pkg::CCF_DW_BYTES;
            next_in_dc = 1'b1;
            next_req = 1'b1;
            next_state = ccf_pkg::CCF_FETCH;
          end
        end else if (dev_byte || dev_end) begin
          // Long block when bytes outrun count, short block at early end
          // Extra bytes are remembered until device end
          if (dev_byte) begin
            next_long_blk = 1'b1;
          end
          len_err = next_long_blk || (dev_end && cnt != ccf_pkg::CCF_CNT_ZERO);
          next_last_done = cur + ccf_pkg::CCF_DW_BYTES;
          next_rcnt = cnt;
          if (dev_end) begin
            next_progress_interrupt_flag_q = flg[ccf_pkg::CCF_FLAG_PROGRESS_INTERRUPT_FLAG - 24];
            if (len_err && (!flg[ccf_pkg::CCF_FLAG_SIL - 24] || flg[ccf_pkg::CCF_FLAG_DC - 24])) begin
              next_st = ccf_pkg::CCF_ST_LEN;
              next_state = ccf_pkg::CCF_QUEUE;
            end else if (flg[ccf_pkg::CCF_FLAG_CC - 24]) begin
              next_cur = cur + ccf_pkg::CCF_DW_BYTES;
              next_in_dc = 1'b0;
              next_req = 1'b1;
              next_state = ccf_pkg::CCF_FETCH;
            end else begin
              next_st = ccf_pkg::CCF_ST_NONE;
              next_state = ccf_pkg::CCF_QUEUE;
            end
          end
        end
        if (dev_end || dev_byte) begin
          next_executed = 1'b1;
        end
      end
      ccf_pkg::CCF_QUEUE: begin
        // A pending progress record takes the push slot first
        if (!q_full && !progress_interrupt_flag_q) begin
          next_state = ccf_pkg::CCF_DONE;
        end
      end
      ccf_pkg::CCF_DONE: begin
        next_state = ccf_pkg::CCF_IDLE;
      end
      default: begin
        next_state = ccf_pkg::CCF_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ccf_pkg::CCF_IDLE;
      word2 <= 1'b0;
      w1 <= '0;
      cmd <= '0;
      flg <= '0;
      cur <= '0;
      last_done <= '0;
      daddr <= '0;
      cnt <= '0;
      executed <= 1'b0;
      in_dc <= 1'b0;
      st <= '0;
      rcnt <= '0;
      progress_interrupt_flag_q <= 1'b0;
      req <= 1'b0;
      was_exec <= 1'b0;
      long_blk <= 1'b0;
      go_pend <= 1'b0;
      list_addr <= '0;
      subaddr <= '0;
      sbuf <= '0;
      sptr <= '0;
    end else begin
      state <= next_state;
      word2 <= next_word2;
      w1 <= next_w1;
      cmd <= next_cmd;
      flg <= next_flg;
      cur <= next_cur;
      last_done <= next_last_done;
      daddr <= next_daddr;
      cnt <= next_cnt;
      executed <= next_executed;
      in_dc <= next_in_dc;
      st <= next_st;
      rcnt <= next_rcnt;
      progress_interrupt_flag_q <= next_progress_interrupt_flag_q;
      req <= next_req;
      was_exec <= next_was_exec;
      long_blk <= next_long_blk;
      go_pend <= next_go_pend;
      list_addr <= next_list_addr;
      subaddr <= next_subaddr;
      sbuf <= next_sbuf;
      sptr <= next_sptr;
    end
  end

  // ****************************************
  // Device side and status records
  // ****************************************
  assign mem_rd_req = req;
  assign mem_rd_addr = word2 ? cur + 24'h00_0004 : cur;
  // First cycle of a command; a zero-count transfer never reaches the device
  assign dev_start = state == ccf_pkg::CCF_EXEC && !was_exec && !in_dc
    && !(is_xfer && cnt == ccf_pkg::CCF_CNT_ZERO);
  assign dev_new_record = dev_start;
  assign dev_cmd = cmd;
  assign data_addr = daddr;
  // Skip suppresses memory writes but device still moves data
  assign data_wr_en = state == ccf_pkg::CCF_EXEC && dev_byte && is_rd
    && cnt != ccf_pkg::CCF_CNT_ZERO && !flg[ccf_pkg::CCF_FLAG_SKIP - 24];
  assign residual = cnt;

  // Progress records take priority slot order; final record in QUEUE state
  logic [15:0] rec_flags, rec_cnt;
  logic [23:0] rec_addr;
  always_comb begin
    if (progress_interrupt_flag_q) begin
      rec_flags = ccf_pkg::CCF_ST_PROGRESS_INTERRUPT_FLAG;
      rec_cnt = ccf_pkg::CCF_CNT_ZERO;
      rec_addr = last_done;
    end else begin
      rec_flags = st;
      rec_cnt = rcnt;
      rec_addr = last_done;
    end
  end
  assign q_push = progress_interrupt_flag_q || (state == ccf_pkg::CCF_QUEUE && !q_full);

  ccf_status_pack u_pack (
    .subaddr(subaddr),
    .cmd_addr(rec_addr),
    .flags(rec_flags),
    .residual(rec_cnt),
    .record(rec)
  );

  ccf_status_queue #(.DEPTH(QDEPTH)) u_queue (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(q_push),
    .push_data(rec),
    .pop(q_pop),
    .head(q_head),
    .not_empty(q_ne),
    .full(q_full)
  );

  always_comb begin
    case (ph_addr)
      ccf_pkg::CCF_REG_CTRL: hrdata = {23'h00_0000, go_pend, subaddr};
      ccf_pkg::CCF_REG_LIST: hrdata = {8'h00, list_addr};
      ccf_pkg::CCF_REG_STAT: hrdata = {27'h000_0000, q_full, q_ne, state};
      ccf_pkg::CCF_REG_SW1: hrdata = q_head[63:32];
      ccf_pkg::CCF_REG_SW2: hrdata = q_head[31:0];
      ccf_pkg::CCF_REG_SPTR: hrdata = {8'h00, sptr};
      ccf_pkg::CCF_REG_SBUF: hrdata = {8'h00, sbuf};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  AST_ZERO_CNT: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ccf_pkg::CCF_EXEC && is_xfer && cnt == ccf_pkg::CCF_CNT_ZERO && !in_dc
    && !was_exec
    |=> st == ccf_pkg::CCF_ST_PCHK && state == ccf_pkg::CCF_QUEUE)
    else $error("zero count did not raise program check");
  AST_SKIP: assert property (@(posedge hclk) disable iff (!hresetn)
    flg[ccf_pkg::CCF_FLAG_SKIP - 24] |-> !data_wr_en)
    else $error("skip still wrote memory");
  AST_PROGRESS_INTERRUPT_FLAG_REC: assert property (@(posedge hclk) disable iff (!hresetn)
    progress_interrupt_flag_q |-> q_push && rec[31:0] == {ccf_pkg::CCF_ST_PROGRESS_INTERRUPT_FLAG, ccf_pkg::CCF_CNT_ZERO})
    else $error("progress record malformed");
  AST_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ccf_pkg::CCF_EXEC && dev_end && cnt != ccf_pkg::CCF_CNT_ZERO
    && !flg[ccf_pkg::CCF_FLAG_SIL - 24] |=> state == ccf_pkg::CCF_QUEUE)
    else $error("length mismatch did not end list");
  AST_QUEUE: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ccf_pkg::CCF_QUEUE && !q_full && !progress_interrupt_flag_q
    |-> q_push ##1 state == ccf_pkg::CCF_DONE)
    else $error("final status not queued");
  AST_PTR: assert property (@(posedge hclk) disable iff (!hresetn)
    q_pop && q_ne |=> sptr == $past(sbuf))
    else $error("status pointer not updated");
  AST_W1: assert property (@(posedge hclk) disable iff (!hresetn)
    q_push |-> rec[63:56] == subaddr && rec[55:32] == last_done)
    else $error("status word one malformed");
  AST_DC_CMD: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ccf_pkg::CCF_FETCH && in_dc |=> $stable(cmd))
    else $error("data chain changed command");
endmodule : ccf_channel

// file: verilog/ccf_pkg.sv
// Shared constants and types for the channel command flag and status block
package ccf_pkg;
  // ****************************************
  // Command doubleword layout (bit 31 = MSB)
  // ****************************************
  localparam int CCF_FLAG_DC = 31;
  localparam int CCF_FLAG_CC = 30;
  localparam int CCF_FLAG_SIL = 29;
  localparam int CCF_FLAG_SKIP = 28;
  localparam int CCF_FLAG_PROGRESS_INTERRUPT_FLAG = 27;
  localparam int CCF_FLAG_HI = 31;
  localparam int CCF_FLAG_LO = 24;
  localparam int CCF_ADDR_HI = 23;
  localparam int CCF_ADDR_LO = 0;
  localparam int CCF_CNT_HI = 15;
  localparam int CCF_CNT_LO = 0;
  localparam int CCF_CMD_HI = 31;
  localparam int CCF_CMD_LO = 24;
  // ****************************************
  // Status flag word, bit n at position 15-n
  // ****************************************
  localparam logic [15:0] CCF_ST_PROGRESS_INTERRUPT_FLAG = 16'h4000;
  localparam logic [15:0] CCF_ST_LEN = 16'h2000;
  localparam logic [15:0] CCF_ST_PCHK = 16'h1000;
  localparam logic [15:0] CCF_ST_DCHK = 16'h0800;
  localparam logic [15:0] CCF_ST_NONE = 16'h0000;
  localparam logic [23:0] CCF_DW_BYTES = 24'h00_0008;
  localparam logic [23:0] CCF_WORD_MASK = 24'hFF_FFFC;
  localparam logic [15:0] CCF_CNT_ZERO = 16'h0000;
  localparam logic [15:0] CCF_CNT_ONE = 16'h0001;
  // ****************************************
  // Command byte classes (low nibble)
  // ****************************************
  localparam logic [3:0] CCF_OP_WRITE = 4'h1;
  localparam logic [3:0] CCF_OP_READ = 4'h2;
  localparam logic [3:0] CCF_OP_SENSE = 4'h4;
  localparam logic [1:0] CCF_OP_MASK_W = 2'h1;
  // ****************************************
  // AHB-Lite
  // ****************************************
  localparam logic [1:0] CCF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CCF_HSIZE_WORD = 3'h2;
  localparam logic [7:0] CCF_REG_CTRL = 8'h00;
  localparam logic [7:0] CCF_REG_LIST = 8'h04;
  localparam logic [7:0] CCF_REG_STAT = 8'h08;
  localparam logic [7:0] CCF_REG_SW1 = 8'h0C;
  localparam logic [7:0] CCF_REG_SW2 = 8'h10;
  localparam logic [7:0] CCF_REG_SPTR = 8'h14;
  localparam logic [7:0] CCF_REG_SBUF = 8'h18;

  typedef enum logic [2:0] {
    CCF_IDLE = 3'h0,
    CCF_FETCH = 3'h1,
    CCF_EXEC = 3'h3,
    CCF_QUEUE = 3'h2,
    CCF_DONE = 3'h6
  } ccf_state_t;
endpackage : ccf_pkg

// file: verilog/ccf_status_queue.sv
// Status record queue holding records in posting order
`timescale 1ns/1ps
module ccf_status_queue #(
  parameter int DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic [63:0] push_data,
  input wire logic pop,
  output logic [63:0] head,
  output logic not_empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [63:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (pop && not_empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Entry storage, one slot per index
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem[g] <= '0;
      end else if (push && !full && wr_ptr[AW-1:0] == AW'(g)) begin
        mem[g] <= push_data;
      end
    end
  end

  assign head = mem[rd_ptr[AW-1:0]];
  assign not_empty = wr_ptr != rd_ptr;
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

  AST_FIFO_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
    pop && not_empty |=> rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("queue read pointer did not advance");
endmodule : ccf_status_queue

// file: verilog/ccf_status_pack.sv
// Status doubleword assembly
`timescale 1ns/1ps
module ccf_status_pack (
  input wire logic [7:0] subaddr,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] flags,
  input wire logic [15:0] residual,
  output logic [63:0] record
);
  // Word 1: subaddress high byte, address low; word 2: flags high, count low
  assign record = {subaddr, cmd_addr, flags, residual};
endmodule : ccf_status_pack

// file: bench/ccf_partner.sv
// Host memory and device controller model facing the channel
`timescale 1ns/1ps
module ccf_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_rd_req,
  input wire logic [23:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_data,
  input wire logic dev_start,
  output logic dev_byte,
  output logic dev_end,
  output logic dev_data_check,
  input wire logic [15:0] rec_len,
  input wire logic dchk,
  input wire logic [1:0] lat
);
  logic [31:0] mem [0:255];
  logic [7:0] idx;
  // Byte spacing leaves room for a data-chain refetch
  localparam int GAP = 12;

  initial begin
    mem_rd_valid = 1'b0;
    mem_rd_data = 32'h0000_0000;
    dev_byte = 1'b0;
    dev_end = 1'b0;
    dev_data_check = 1'b0;
  end

  // ****************************************
  // Memory: answers each fetch after lat cycles
  // ****************************************
  always begin
    @(posedge hclk);
    if (hresetn === 1'b1 && mem_rd_req === 1'b1) begin
      idx = mem_rd_addr[9:2];
      repeat (lat) @(posedge hclk);
      mem_rd_valid <= 1'b1;
      mem_rd_data <= mem[idx];
      @(posedge hclk);
      mem_rd_valid <= 1'b0;
      // Released bus shows no stale word
      mem_rd_data <= ~mem[idx];
    end
  end

  // ****************************************
  // Device: one record of rec_len bytes, then end
  // ****************************************
  always begin
    @(posedge hclk);
    if (hresetn === 1'b1 && dev_start === 1'b1) begin
      repeat (rec_len) begin
        repeat (GAP) @(posedge hclk);
        dev_byte <= 1'b1;
        @(posedge hclk);
        dev_byte <= 1'b0;
      end
      @(posedge hclk);
      dev_end <= 1'b1;
      dev_data_check <= dchk;
      @(posedge hclk);
      dev_end <= 1'b0;
      dev_data_check <= 1'b0;
    end
  end
endmodule : ccf_partner

// file: bench/channel_command_flags_status_bench.sv
// Self-checking bench for the channel command flag and status block
`timescale 1ns/1ps
module channel_command_flags_status_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_rd_req, mem_rd_valid;
  logic [31:0] haddr, hwdata, hrdata, mem_rd_data, rd, seed;
  logic [1:0] htrans, lat;
  logic [2:0] hsize;
  logic [23:0] mem_rd_addr, data_addr;
  logic dev_start, dev_new_record, dev_byte, dev_end, dev_data_check, data_wr_en, dchk;
  logic [7:0] dev_cmd, last_cmd, sub, op;
  logic [15:0] residual, rec_len, cnt;
  int n_errors, checked, wr_cnt, starts, k;

  ccf_channel dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .dev_start(dev_start), .dev_cmd(dev_cmd), .dev_new_record(dev_new_record),
    .dev_byte(dev_byte), .dev_end(dev_end), .dev_data_check(dev_data_check),
    .data_addr(data_addr), .data_wr_en(data_wr_en), .residual(residual));
  ccf_partner pu (.hclk(hclk), .hresetn(hresetn), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .dev_start(dev_start), .dev_byte(dev_byte), .dev_end(dev_end),
    .dev_data_check(dev_data_check), .rec_len(rec_len), .dchk(dchk), .lat(lat));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (data_wr_en === 1'b1) wr_cnt <= wr_cnt + 1;
    if (dev_new_record === 1'b1) starts <= starts + 1;
    if (dev_start === 1'b1) last_cmd <= dev_cmd;
  end

  // ****************************************
  // Bus, compare and list helpers
  // ****************************************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= ccf_pkg::CCF_HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hsize <= ccf_pkg::CCF_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cdw(input int i, input logic [7:0] c, input logic [7:0] f, input logic [15:0] n);
    pu.mem[64 + 2 * i] = {c, 24'h00_0800};
    pu.mem[65 + 2 * i] = {f, 8'h00, n};
  endtask : cdw

  task automatic go;
    wr_cnt = 0;
    starts = 0;
    sub = 8'($urandom);
    ahb(1'b1, ccf_pkg::CCF_REG_LIST, 32'h0000_0100);
    ahb(1'b1, ccf_pkg::CCF_REG_CTRL, {23'h00_0000, 1'b1, sub});
  endtask : go

  task automatic pop(input logic [23:0] ea, input logic [15:0] ef, input logic [15:0] er);
    int i;
    i = 0;
    do begin
      ahb(1'b0, ccf_pkg::CCF_REG_STAT, 32'h0000_0000);
      i++;
    end while (rd[3] !== 1'b1 && i < 400);
    chk(32'(rd[3]), 32'h0000_0001);
    ahb(1'b0, ccf_pkg::CCF_REG_SW1, 32'h0000_0000);
    chk(rd, {sub, ea});
    ahb(1'b0, ccf_pkg::CCF_REG_SW2, 32'h0000_0000);
    chk(rd, {ef, er});
    ahb(1'b0, ccf_pkg::CCF_REG_SPTR, 32'h0000_0000);
    chk(rd, 32'h0000_0400);
  endtask : pop

  task automatic one(input logic [7:0] f, input logic [15:0] c, input logic [15:0] r,
                     input logic d, input logic [23:0] ea, input logic [15:0] ef,
                     input logic [15:0] er);
    cdw(0, ccf_pkg::CCF_OP_READ, f, c);
    cdw(1, ccf_pkg::CCF_OP_READ, 8'h00, r);
    rec_len = r;
    dchk = d;
    go();
    pop(ea, ef, er);
    dchk = 1'b0;
    repeat (40) @(posedge hclk);
  endtask : one

  function automatic logic [7:0] op_of(input int i);
    case (i % 3)
      0: op_of = {4'h0, ccf_pkg::CCF_OP_READ};
      1: op_of = {4'h0, ccf_pkg::CCF_OP_WRITE};
      default: op_of = {4'h0, ccf_pkg::CCF_OP_SENSE};
    endcase
  endfunction : op_of

  task end_of_test;
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {hsel, hwrite, dchk} = 3'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h0;
    lat = 2'h0;
    rec_len = 16'h0000;
    hresetn = 1'b0;
    seed = $urandom(32'h2360);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, ccf_pkg::CCF_REG_SBUF, 32'h0000_0400);
    ahb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (k = 0; k < 9; k++) begin
      op = op_of(k);
      cnt = 16'(1 + $urandom % 8);
      lat = 2'($urandom);
      rec_len = cnt;
      cdw(0, op, 8'h00, cnt);
      go();
      pop(24'h00_0108, ccf_pkg::CCF_ST_NONE, ccf_pkg::CCF_CNT_ZERO);
      chk(32'(last_cmd), 32'(op));
      if (k % 3 == 0) chk(wr_cnt, 32'(cnt));
      repeat (40) @(posedge hclk);
    end
    one(8'h40, 16'h0005, 16'h0003, 1'b0, 24'h00_0108, ccf_pkg::CCF_ST_LEN, 16'h0002);
    one(8'h60, 16'h0005, 16'h0003, 1'b0, 24'h00_0110, ccf_pkg::CCF_ST_NONE, 16'h0000);
    chk(starts, 2);
    one(8'h20, 16'h0005, 16'h0003, 1'b0, 24'h00_0108, ccf_pkg::CCF_ST_NONE, 16'h0002);
    one(8'h00, 16'h0002, 16'h0004, 1'b0, 24'h00_0108, ccf_pkg::CCF_ST_LEN, 16'h0000);
    one(8'h10, 16'h0004, 16'h0004, 1'b0, 24'h00_0108, ccf_pkg::CCF_ST_NONE, 16'h0000);
    chk(wr_cnt, 0);
    one(8'h00, 16'h0002, 16'h0002, 1'b1, 24'h00_0108, ccf_pkg::CCF_ST_DCHK, 16'h0000);
    cdw(0, ccf_pkg::CCF_OP_READ, 8'h48, 16'h0003);
    cdw(1, ccf_pkg::CCF_OP_READ, 8'h00, 16'h0003);
    rec_len = 16'h0003;
    go();
    pop(24'h00_0108, ccf_pkg::CCF_ST_PROGRESS_INTERRUPT_FLAG, ccf_pkg::CCF_CNT_ZERO);
    pop(24'h00_0110, ccf_pkg::CCF_ST_NONE, ccf_pkg::CCF_CNT_ZERO);
    repeat (40) @(posedge hclk);
    cdw(0, ccf_pkg::CCF_OP_READ, 8'h80, 16'h0002);
    cdw(1, ccf_pkg::CCF_OP_WRITE, 8'h00, 16'h0003);
    rec_len = 16'h0005;
    go();
    pop(24'h00_0110, ccf_pkg::CCF_ST_NONE, ccf_pkg::CCF_CNT_ZERO);
    chk(starts, 1);
    chk(32'(last_cmd), 32'(ccf_pkg::CCF_OP_READ));
    chk(wr_cnt, 5);
    repeat (40) @(posedge hclk);
    one(8'hA0, 16'h0004, 16'h0002, 1'b0, 24'h00_0108, ccf_pkg::CCF_ST_LEN, 16'h0002);
    for (k = 0; k < 3; k++) begin
      cdw(0, op_of(k), 8'h00, 16'h0000);
      go();
      pop(24'h00_0100, ccf_pkg::CCF_ST_PCHK, ccf_pkg::CCF_CNT_ZERO);
      repeat (40) @(posedge hclk);
    end
    end_of_test();
  end
endmodule : channel_command_flags_status_bench
